// ### core/smpc_regs.vh
// Constants for the sleep-mode power controller
`ifndef SMPC_REGS_VH
`define SMPC_REGS_VH

// Controller states
`define SMPC_ST_RUN 3'h0
`define SMPC_ST_ENTER 3'h1
`define SMPC_ST_SLEEP 3'h2
`define SMPC_ST_REGWAIT 3'h3
`define SMPC_ST_WAKE 3'h4

// Widths
`define SMPC_PIN_W 16
`define SMPC_CLKSEL_W 3
`define SMPC_CNT_W 13

// Regulator recovery time in ns and its cycle count at 100 MHz (10 ns period), rounded up
`define SMPC_REGULATOR_WAKE_DELAY_NS 10000
`define SMPC_CLK_NS 10
`define SMPC_REGULATOR_WAKE_DELAY_CYC ((`SMPC_REGULATOR_WAKE_DELAY_NS + `SMPC_CLK_NS - 1) / `SMPC_CLK_NS)
// Recovery counter load value: SMPC_REGULATOR_WAKE_DELAY_CYC minus one, sized to SMPC_CNT_W
`define SMPC_REGULATOR_WAKE_DELAY_LAST 13'h03e7

// Fuse level that allows the retention regulator
`define SMPC_FUSE_ON 1'b0

`endif

// ### core/smpc_hold.v
// Register that captures a value on a load strobe and holds it otherwise
`default_nettype none

module smpc_hold #(
    parameter W = 1
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Load control
    input wire load,
    input wire [W-1:0] d,
    input wire [W-1:0] rst_val,
    // Held value
    output reg [W-1:0] q
);

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= {W{1'b0}};
        end else if (load) begin
            q <= d;
        end
    end

endmodule // smpc_hold

`default_nettype wire

// ### core/smpc_sleep_ctrl.v
// Sleep-mode power controller: entry, hold, wake and regulator recovery
`include "smpc_regs.vh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - on sleep entry the system clock source and its on-chip oscillator are turned off.
// - while asleep every pin direction and output level stays frozen at its entry value.
// - the fail-safe clock monitor is disabled for the whole sleep period.
// - in sleep the low-power RC clock runs if the watchdog, or the calendar clock fed by it, is enabled.
// - an enabled watchdog count is cleared just before sleep is entered.
// - system-clock peripherals are gated in sleep; input change notify and external-clock peripherals keep running.
// - sleep ends on an enabled interrupt, any reset, or a watchdog time-out.
// - on wake the core resumes on the clock source selected at entry.
// - retention sleep behaves as sleep except the core supply may drop to its retention level.
// - waking from retention sleep waits the regulator recovery delay before resuming.
// - the retention regulator is used only when the fuse is zero and the firmware keep-enable bit is one.
// - an interrupt coinciding with the sleep request is held until entry completes, then wakes the device.
module smpc_sleep_ctrl (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Core request
    input wire power_save_instruction,
    input wire [`SMPC_CLKSEL_W-1:0] clk_sel_in,
    // Wake sources
    input wire irq_pending,
    input wire watchdog_timeout,
    // Configuration
    input wire watchdog_enable,
    input wire calendar_clock_enable,
    input wire calendar_clock_on_low_power_rc_clock,
    input wire fail_safe_enable,
    input wire lowpower_fuse_config,
    input wire low_voltage_keep_enable,
    // Pin state from the port logic
    input wire [`SMPC_PIN_W-1:0] pin_dir_in,
    input wire [`SMPC_PIN_W-1:0] pin_out_in,
    // Clock and power controls
    output reg sys_osc_enable,
    output reg low_power_rc_clock_enable,
    output reg fail_safe_clock_monitor_enable,
    output reg periph_clk_enable,
    output reg input_change_notify_enable,
    output reg retention_reg_enable,
    output reg watchdog_counter_clear,
    output reg [`SMPC_CLKSEL_W-1:0] clk_sel_out,
    // Frozen pins
    output reg pin_freeze,
    output reg [`SMPC_PIN_W-1:0] pin_dir_out,
    output reg [`SMPC_PIN_W-1:0] pin_out_out,
    // Core status
    output reg core_halt,
    output reg wake_pulse
);

    ////////////////////////////////////////////////////////////////////////////
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [`SMPC_CNT_W-1:0] cnt_reg;
    reg [`SMPC_CNT_W-1:0] cnt_next;
    reg irq_held_reg;
    reg ret_reg;
    wire [`SMPC_CLKSEL_W-1:0] clk_saved;
    wire [`SMPC_PIN_W-1:0] dir_saved;
    wire [`SMPC_PIN_W-1:0] out_saved;
    wire entering;
    wire asleep;
    wire wake_evt;
    wire ret_allowed;
    wire sleep_next;
    wire [`SMPC_CNT_W-1:0] regulator_wake_delay_load;

    // Sleep request is a single-cycle pulse from the core
    assign entering = (state_reg == `SMPC_ST_RUN) && power_save_instruction;
    assign asleep = (state_reg == `SMPC_ST_SLEEP) || (state_reg == `SMPC_ST_REGWAIT);
    assign ret_allowed = (lowpower_fuse_config == `SMPC_FUSE_ON) && low_voltage_keep_enable;
    // Reset wake is implied: rst_n returns the block to run
    assign wake_evt = irq_pending || irq_held_reg || watchdog_timeout;
    // Clocks and peripherals stay off through sleep and the regulator wait
    assign sleep_next = (state_next == `SMPC_ST_SLEEP) || (state_next == `SMPC_ST_REGWAIT);
    // Recovery counter start value, already at the counter's width
    assign regulator_wake_delay_load = `SMPC_REGULATOR_WAKE_DELAY_LAST;

    ////////////////////////////////////////////////////////////////////////////
    // Entry snapshots
    smpc_hold #(.W(`SMPC_CLKSEL_W)) u_clk_hold (
        .clock(clock),
        .rst_n(rst_n),
        .load(entering),
        .d(clk_sel_in),
        .rst_val({`SMPC_CLKSEL_W{1'b0}}),
        .q(clk_saved)
    );

    smpc_hold #(.W(`SMPC_PIN_W)) u_dir_hold (
        .clock(clock),
        .rst_n(rst_n),
        .load(entering),
        .d(pin_dir_in),
        .rst_val({`SMPC_PIN_W{1'b0}}),
        .q(dir_saved)
    );

    smpc_hold #(.W(`SMPC_PIN_W)) u_out_hold (
        .clock(clock),
        .rst_n(rst_n),
        .load(entering),
        .d(pin_out_in),
        .rst_val({`SMPC_PIN_W{1'b0}}),
        .q(out_saved)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State machine
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            `SMPC_ST_RUN: begin
                if (power_save_instruction) begin
                    state_next = `SMPC_ST_ENTER;
                end
            end
            `SMPC_ST_ENTER: begin
                state_next = `SMPC_ST_SLEEP;
            end
            `SMPC_ST_SLEEP: begin
                if (wake_evt) begin
                    if (ret_reg) begin
                        state_next = `SMPC_ST_REGWAIT;
                        cnt_next = regulator_wake_delay_load;
                    end else begin
                        state_next = `SMPC_ST_WAKE;
                    end
                end
            end
            `SMPC_ST_REGWAIT: begin
                if (cnt_reg == {`SMPC_CNT_W{1'b0}}) begin
                    state_next = `SMPC_ST_WAKE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            `SMPC_ST_WAKE: begin
                state_next = `SMPC_ST_RUN;
            end
            default: begin
                state_next = `SMPC_ST_RUN;
            end
        endcase
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= `SMPC_ST_RUN;
            cnt_reg <= {`SMPC_CNT_W{1'b0}};
            irq_held_reg <= 1'b0;
            ret_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            // Interrupt seen with the request or during entry is kept until the wake state clears it,
            // so a short pulse that lands before the clocks stop still wakes the device
            if ((entering || state_reg == `SMPC_ST_ENTER) && irq_pending) begin
                irq_held_reg <= 1'b1;
            end else if (state_reg == `SMPC_ST_WAKE) begin
                irq_held_reg <= 1'b0;
            end
            if (entering) begin
                ret_reg <= ret_allowed;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sys_osc_enable <= 1'b1;
            low_power_rc_clock_enable <= 1'b0;
            fail_safe_clock_monitor_enable <= 1'b0;
            periph_clk_enable <= 1'b1;
            input_change_notify_enable <= 1'b1;
            retention_reg_enable <= 1'b0;
            watchdog_counter_clear <= 1'b0;
            clk_sel_out <= {`SMPC_CLKSEL_W{1'b0}};
            pin_freeze <= 1'b0;
            pin_dir_out <= {`SMPC_PIN_W{1'b0}};
            pin_out_out <= {`SMPC_PIN_W{1'b0}};
            core_halt <= 1'b0;
            wake_pulse <= 1'b0;
        end else begin
            sys_osc_enable <= !sleep_next;
            periph_clk_enable <= !sleep_next;
            input_change_notify_enable <= 1'b1;
            // The monitor has nothing to watch once the system clock is stopped
            fail_safe_clock_monitor_enable <= fail_safe_enable && (state_next == `SMPC_ST_RUN);
            if (state_next == `SMPC_ST_RUN) begin
                low_power_rc_clock_enable <= watchdog_enable || fail_safe_enable ||
                    (calendar_clock_enable && calendar_clock_on_low_power_rc_clock);
            end else begin
                low_power_rc_clock_enable <= watchdog_enable ||
                    (calendar_clock_enable && calendar_clock_on_low_power_rc_clock);
            end
            watchdog_counter_clear <= entering && watchdog_enable;
            retention_reg_enable <= ret_reg && (state_next == `SMPC_ST_SLEEP);
            // Leave the live select only once the snapshot holds it, so the entry edge cannot glitch
            clk_sel_out <= (state_reg == `SMPC_ST_RUN) ? clk_sel_in : clk_saved;
            pin_freeze <= asleep || state_reg == `SMPC_ST_ENTER;
            pin_dir_out <= (asleep || state_reg == `SMPC_ST_ENTER) ? dir_saved : pin_dir_in;
            pin_out_out <= (asleep || state_reg == `SMPC_ST_ENTER) ? out_saved : pin_out_in;
            core_halt <= state_next != `SMPC_ST_RUN;
            wake_pulse <= state_reg == `SMPC_ST_WAKE;
        end
    end

endmodule // smpc_sleep_ctrl

`default_nettype wire

// ### test/smpc_asserts.sv
// Assertion checker for the sleep-mode power controller
`default_nettype none
module smpc_asserts (
    // Clock, reset and inputs
    input wire logic clock,
    input wire logic rst_n,
    input wire logic power_save_instruction,
    input wire logic irq_pending,
    input wire logic watchdog_timeout,
    input wire logic watchdog_enable,
    input wire logic calendar_clock_enable,
    input wire logic calendar_clock_on_low_power_rc_clock,
    input wire logic lowpower_fuse_config,
    input wire logic low_voltage_keep_enable,
    // Outputs
    input wire logic sys_osc_enable,
    input wire logic low_power_rc_clock_enable,
    input wire logic fail_safe_clock_monitor_enable,
    input wire logic periph_clk_enable,
    input wire logic retention_reg_enable,
    input wire logic watchdog_counter_clear,
    input wire logic [2:0] clk_sel_out,
    input wire logic pin_freeze,
    input wire logic [15:0] pin_dir_out,
    input wire logic core_halt,
    input wire logic wake_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int REGULATOR_WAKE_DELAY_LO = 1000;
    localparam int REGULATOR_WAKE_DELAY_HI = 1010;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire ret_on = !lowpower_fuse_config && low_voltage_keep_enable;
    wire wake_src = irq_pending || watchdog_timeout;
    wire low_power_rc_clock_need = watchdog_enable || calendar_clock_enable && calendar_clock_on_low_power_rc_clock;
    // Cycles spent waiting for the regulator after a retention wake
    logic [10:0] rw_cnt;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rw_cnt <= 11'h000;
        end else if (sys_osc_enable) begin
            rw_cnt <= 11'h000;
        end else if (ret_on && !retention_reg_enable) begin
            rw_cnt <= rw_cnt + 11'h001;
        end
    end
    sequence s_entry;
        power_save_instruction && !core_halt ##1 core_halt;
    endsequence
    sequence s_asleep;
        !sys_osc_enable && !periph_clk_enable && pin_freeze;
    endsequence
    chk_halt_on_req: assert property (power_save_instruction && !core_halt |=> core_halt)
        else $error("core_halt not raised after request");
    chk_clocks_off: assert property (s_entry |=> s_asleep)
        else $error("clock or peripherals still on in sleep");
    chk_pins_frozen: assert property (pin_freeze && $past(pin_freeze) |-> $stable(pin_dir_out))
        else $error("pin direction moved while frozen");
    chk_fail_safe_clock_monitor_off: assert property (!sys_osc_enable |-> !fail_safe_clock_monitor_enable)
        else $error("clock monitor active in sleep");
    chk_low_power_rc_clock_kept: assert property (!sys_osc_enable && low_power_rc_clock_need |-> low_power_rc_clock_enable)
        else $error("low power clock stopped in sleep");
    chk_wdt_clear: assert property ($rose(core_halt) |-> watchdog_counter_clear == watchdog_enable)
        else $error("watchdog clear wrong at entry");
    chk_sel_hold: assert property (core_halt && $past(core_halt) |-> $stable(clk_sel_out))
        else $error("clock select moved in sleep");
    chk_wake_fast: assert property (!sys_osc_enable && !ret_on && wake_src |-> ##[1:3] wake_pulse)
        else $error("no wake after wake event");
    chk_low_voltage_keep_enable_wake: assert property ($rose(sys_osc_enable) && ret_on |-> rw_cnt >= REGULATOR_WAKE_DELAY_LO && rw_cnt <= REGULATOR_WAKE_DELAY_HI)
        else $error("retention wake delay wrong");
    chk_low_voltage_keep_enable_bound: assert property (rw_cnt <= REGULATOR_WAKE_DELAY_HI)
        else $error("regulator wait too long");
    chk_wake_pulse: assert property ($rose(sys_osc_enable) |=> wake_pulse)
        else $error("no wake pulse after clock restart");
    chk_low_voltage_keep_enable_gate: assert property (retention_reg_enable |-> ret_on && !sys_osc_enable)
        else $error("retention regulator on without permission");
endmodule // smpc_asserts
bind smpc_sleep_ctrl smpc_asserts u_chk (.clock, .rst_n, .power_save_instruction, .irq_pending,
    .watchdog_timeout, .watchdog_enable, .calendar_clock_enable, .calendar_clock_on_low_power_rc_clock, .lowpower_fuse_config,
    .low_voltage_keep_enable, .sys_osc_enable, .low_power_rc_clock_enable, .fail_safe_clock_monitor_enable,
    .periph_clk_enable, .retention_reg_enable, .watchdog_counter_clear, .clk_sel_out, .pin_freeze,
    .pin_dir_out, .core_halt, .wake_pulse);
`default_nettype wire

// ### test/smpc_core_model.sv
// Processor core model that issues one-cycle sleep requests
`default_nettype none
module smpc_core_model (
    // Clock
    input wire logic clock,
    // Sleep request
    output var logic power_save_instruction
);
    timeunit 1ns;
    timeprecision 1ns;
    initial power_save_instruction = 1'b0;
    task automatic sleep_req(input int gap);
        repeat (gap + 1) @(negedge clock);
        power_save_instruction = 1'b1;
        @(negedge clock);
        power_save_instruction = 1'b0;
    endtask
endmodule // smpc_core_model
`default_nettype wire

// ### test/tb.sv
// Self-checking testbench for the sleep-mode power controller
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, rst_n = 1'b0, irq = 1'b0, wdt_to = 1'b0, psv;
    logic wd_en = 1'b0, cal_en = 1'b0, cal_low_power_rc_clock = 1'b0, fuse = 1'b1, keep = 1'b0, fs_en = 1'b1;
    logic [2:0] sel_in = 3'h5;
    logic [15:0] dir_in = 16'h5a5a, out_in = 16'h0ff0;
    wire osc, low_power_rc_clock, fail_safe_clock_monitor, periph, input_change_notify, ret, clr, freeze, halt, wake;
    wire [2:0] sel_out;
    wire [15:0] dir_out, out_out;
    int error_cnt = 0, cmp_count = 0;
    initial forever #5 clock = ~clock;
    smpc_core_model u_core (.clock(clock), .power_save_instruction(psv));
    smpc_sleep_ctrl u_dut (.clock(clock), .rst_n(rst_n), .power_save_instruction(psv), .clk_sel_in(sel_in),
        .irq_pending(irq), .watchdog_timeout(wdt_to), .watchdog_enable(wd_en), .calendar_clock_enable(cal_en),
        .calendar_clock_on_low_power_rc_clock(cal_low_power_rc_clock), .fail_safe_enable(fs_en), .lowpower_fuse_config(fuse),
        .low_voltage_keep_enable(keep), .pin_dir_in(dir_in), .pin_out_in(out_in), .sys_osc_enable(osc),
        .low_power_rc_clock_enable(low_power_rc_clock), .fail_safe_clock_monitor_enable(fail_safe_clock_monitor), .periph_clk_enable(periph),
        .input_change_notify_enable(input_change_notify), .retention_reg_enable(ret), .watchdog_counter_clear(clr),
        .clk_sel_out(sel_out), .pin_freeze(freeze), .pin_dir_out(dir_out), .pin_out_out(out_out),
        .core_halt(halt), .wake_pulse(wake));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results();
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Config bits: watchdog, calendar, calendar on LOW_POWER_RC_CLOCK, fuse, keep; src 0 irq, 1 watchdog, 2 early irq, 3 reset
    task automatic run_sleep(input logic [4:0] cfg, input int src);
        int n;
        logic [2:0] s0;
        n = 0;
        {wd_en, cal_en, cal_low_power_rc_clock, fuse, keep} = cfg;
        s0 = sel_in;
        u_core.sleep_req(src % 2);
        if (src == 2) irq = 1'b1;
        chk("halt", 1, halt);
        chk("wdt_clear", cfg[4], clr);
        @(negedge clock);
        // An early interrupt is gone before sleep; only its held copy can wake
        irq = 1'b0;
        chk("osc_periph_icn_frz", 4'b0011, {osc, periph, input_change_notify, freeze});
        chk("fail_safe_clock_monitor", 0, fail_safe_clock_monitor);
        chk("low_power_rc_clock", cfg[4] | cfg[3] & cfg[2], low_power_rc_clock);
        chk("retention", !cfg[1] & cfg[0], ret);
        if (src != 2) begin
            dir_in = ~dir_in;
            out_in = ~out_in;
            sel_in = sel_in + 3'h1;
            repeat (3) @(negedge clock);
            chk("pin_dir", ~dir_in, dir_out);
            chk("pin_out", ~out_in, out_out);
            chk("clk_sel", s0, sel_out);
            wdt_to = (src == 1);
            irq = (src == 0);
        end
        if (src == 3) begin
            rst_n = 1'b0;
            @(negedge clock);
            chk("reset_wake", 2'b01, {halt, osc});
            rst_n = 1'b1;
        end else begin
            while (wake !== 1'b1 && n < 1100) begin
                @(negedge clock);
                n++;
            end
            chk("wake_pulse", 1, wake);
            chk("low_voltage_keep_enable_delay", !cfg[1] & cfg[0], n > 900);
        end
        irq = 1'b0;
        wdt_to = 1'b0;
        @(negedge clock);
        chk("run_state", {2'b01, fs_en, 1'b0}, {halt, osc, fail_safe_clock_monitor, freeze});
        $display("Test done, config %b source %0d", cfg, src);
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("reset_outs", 8'he0, {osc, periph, input_change_notify, halt, freeze, ret, clr, wake});
        $display("Test done, reset values");
    endtask
    task automatic t_sleep_irq(); run_sleep(5'b10010, 0); endtask
    task automatic t_sleep_wdt(); run_sleep(5'b11110, 1); endtask
    task automatic t_coincident(); run_sleep(5'b01010, 2); endtask
    task automatic t_retention(); run_sleep(5'b00001, 0); endtask
    task automatic t_fuse_blocks();
        fs_en = 1'b0;
        run_sleep(5'b00011, 0);
        fs_en = 1'b1;
    endtask
    task automatic t_reset_wake(); run_sleep(5'b10010, 3); endtask
    initial begin
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        t_reset();
        t_sleep_irq();
        t_sleep_wdt();
        t_coincident();
        t_retention();
        t_fuse_blocks();
        t_reset_wake();
        results();
    end
    initial begin
        #60000;
        error_cnt++;
        results();
    end
endmodule // tb
`default_nettype wire
